//--- core/pswt_top.sv
// Pin select watchdog: startup delay, kick supervision, timeout pulse.
// Assumes kick and select inputs are synchronous to mclk_in.
//
// Behaviour
// R01: Host toggles kick before each timeout.
// R02: Missed kick deadline asserts the watchdog output.
// R03: Startup delay first, no timeout during it.
// R04: After startup, supervise with selected timeout.
// R05: Pulse 100 ms open drain, 1 ms push-pull.
// R06: Timeout is a low pulse, then high.
// R07: Select changes apply live, no power cycle.
// R08: Code 011 disables supervision entirely.
// R09: Startup 1-3, 10-30, 30-90 ms codes 0-2.
// R10: Startup 100-300 ms code 4, 1-3 s code 5.
// R11: Startup 10-30 s code 6, 60-180 s code 7.
// R12: Timeout table follows the same select codes.
// R13: Kick edges and pulse end restart counter.
// R14: Intervals count ticks of internal time base.
`timescale 1ns/1ps
`default_nettype none
`include "pswt_cfg.svh"

module pswt_top #(
    parameter int unsigned TICK_CYCLES = `PSWT_TICK_NS / `PSWT_CLK_NS,
    parameter bit          OPEN_DRAIN  = 1'b1
) (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic srst_in,
    // Host kick and select straps
    input  wire logic kick_input_in,
    input  wire logic period_select_bit0_in,
    input  wire logic period_select_bit1_in,
    input  wire logic period_select_bit2_in,
    // Watchdog pin, output and enable
    output var  logic timeout_pulse_n_out,
    output var  logic timeout_pulse_oe_out
);

    // Last divider value before a tick
    localparam logic [16:0] DIV_LAST = 17'(TICK_CYCLES - 1);
    // Pulse width chosen by the output variant
    localparam logic [17:0] PULSE_MS = OPEN_DRAIN ? `PSWT_PULSE_OD_MS
                                                  : `PSWT_PULSE_PP_MS;

    // Decoded terminal count for a select code, in ticks
    function automatic logic [17:0] sel_term(input logic [2:0] s);
        logic [17:0] t;
        t = `PSWT_T000_MS;
        unique case (s)
            3'h0: t = `PSWT_T000_MS;
            3'h1: t = `PSWT_T001_MS;
            3'h2: t = `PSWT_T010_MS;
            3'h3: t = `PSWT_T000_MS;
            3'h4: t = `PSWT_T100_MS;
            3'h5: t = `PSWT_T101_MS;
            3'h6: t = `PSWT_T110_MS;
            3'h7: t = `PSWT_T111_MS;
        endcase
        return t;
    endfunction

    pswt_pkg::pswt_reg_t q;        // Registered state
    pswt_pkg::pswt_reg_t d;        // Next state
    logic [2:0]          sel;      // Live select code
    logic                off;      // Supervision switched off
    logic                tick;     // One cycle time base pulse
    logic                kick_edge; // Either edge on kick input
    logic [17:0]         cnt_nx;   // Counter plus one tick
    logic [17:0]         term;     // Current startup or timeout count

    // Select is decoded every cycle so a change takes effect at once
    // R07: live select decode
    assign sel  = {period_select_bit2_in, period_select_bit1_in,
                   period_select_bit0_in};
    // R08: disable code decode
    assign off  = (sel == `PSWT_SEL_OFF);
    // R09: startup and timeout share one table for this variant
    // R10: startup table upper codes
    // R11: startup table long codes
    // R12: timeout table lookup
    assign term = sel_term(sel);
    // R14: tick from the divider
    assign tick      = (q.div == DIV_LAST);
    assign kick_edge = kick_input_in ^ q.kick_prev;
    assign cnt_nx    = q.cnt + 18'h00001;

    // Next state logic for the whole watchdog
    always_comb begin
        d           = q;
        d.div       = tick ? 17'h00000 : q.div + 17'h00001;
        d.kick_prev = kick_input_in;
        unique case (q.st)
            // R03: startup delay, kicks ignored, no timeout
            pswt_pkg::ST_START: begin
                if (tick) begin
                    d.cnt = cnt_nx;
                    // R04: normal supervision after startup
                    if (cnt_nx >= term) begin
                        d.st  = pswt_pkg::ST_RUN;
                        d.cnt = 18'h00000;
                        d.div = 17'h00000;
                    end
                end
            end
            pswt_pkg::ST_RUN: begin
                // R13: kick edge restarts the count
                if (kick_edge) begin
                    d.cnt = 18'h00000;
                    d.div = 17'h00000;
                end else if (tick) begin
                    d.cnt = cnt_nx;
                    // R02: deadline missed, start the pulse
                    if (cnt_nx >= term) begin
                        d.st    = pswt_pkg::ST_PULSE;
                        d.cnt   = 18'h00000;
                        d.div   = 17'h00000;
                        d.wdo_n = 1'b0;
                    end
                end
            end
            // Kicks during the pulse are ignored; the host is in reset
            pswt_pkg::ST_PULSE: begin
                if (tick) begin
                    d.cnt = cnt_nx;
                    // R06: release high after the width
                    // R13: pulse end restarts the count
                    if (cnt_nx >= PULSE_MS) begin
                        d.st    = pswt_pkg::ST_RUN;
                        d.cnt   = 18'h00000;
                        d.div   = 17'h00000;
                        d.wdo_n = 1'b1;
                    end
                end
            end
            // Leaving the off code replays the startup delay
            pswt_pkg::ST_OFF: begin
                if (!off) begin
                    d.st  = pswt_pkg::ST_START;
                    d.cnt = 18'h00000;
                    d.div = 17'h00000;
                end
            end
        endcase
        // R08: off code overrides every state, even a running pulse; only reset wins over it
        if (off) begin
            d.st    = pswt_pkg::ST_OFF;
            d.cnt   = 18'h00000;
            d.wdo_n = 1'b1;
        end
        // R05: open drain drives only while low, push-pull always
        d.oe = OPEN_DRAIN ? ~d.wdo_n : 1'b1;
        if (srst_in) begin
            d.st        = pswt_pkg::ST_START;
            d.div       = 17'h00000;
            d.cnt       = 18'h00000;
            d.kick_prev = 1'b0;
            d.wdo_n     = 1'b1;
            d.oe        = ~OPEN_DRAIN;
        end
    end

    // Single state register
    always_ff @(posedge mclk_in) begin
        q <= d;
    end

    assign timeout_pulse_n_out  = q.wdo_n;
    assign timeout_pulse_oe_out = q.oe;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    // R03: quiet startup
    start_quiet_a: assert property ( // R03
        q.st == pswt_pkg::ST_START |-> q.wdo_n)
        else $error("output low during startup delay");
    // R08: disable code
    off_quiet_a: assert property ( // R08
        off |=> q.wdo_n && q.st == pswt_pkg::ST_OFF)
        else $error("output active while disabled");
    // R02: timeout pulse
    expire_pulse_a: assert property ( // R02
        q.st == pswt_pkg::ST_RUN && !kick_edge && !off && tick &&
        cnt_nx >= term |=> !q.wdo_n && q.st == pswt_pkg::ST_PULSE)
        else $error("missed deadline did not pulse");
    // R06: low only in pulse
    low_cause_a: assert property ( // R06
        !q.wdo_n |-> q.st == pswt_pkg::ST_PULSE)
        else $error("output low outside pulse");
    // R05: pulse width end
    pulse_end_a: assert property ( // R05
        q.st == pswt_pkg::ST_PULSE && !off && tick &&
        cnt_nx >= PULSE_MS |=> q.wdo_n ##1 q.wdo_n)
        else $error("pulse did not end at width");
    // R05: pulse held
    pulse_hold_a: assert property ( // R05
        q.st == pswt_pkg::ST_PULSE && !off &&
        !(tick && cnt_nx >= PULSE_MS) |=> !q.wdo_n)
        else $error("pulse ended early");
    // R13: kick restart
    kick_restart_a: assert property ( // R13
        q.st == pswt_pkg::ST_RUN && kick_edge && !off |=>
        q.cnt == 18'h00000 && q.div == 17'h00000 && q.wdo_n)
        else $error("kick did not restart count");
    // R04: startup hands over
    start_done_a: assert property ( // R04
        q.st == pswt_pkg::ST_START && !off && tick && cnt_nx >= term
        |=> q.st == pswt_pkg::ST_RUN && q.cnt == 18'h00000)
        else $error("startup did not hand over");
    // R14: divider bound
    div_bound_a: assert property ( // R14
        q.div <= DIV_LAST && (q.st == pswt_pkg::ST_OFF ||
        q.cnt <= sel_term(3'h7)))
        else $error("time base out of range");
    // R05: enable pattern
    oe_form_a: assert property ( // R05
        q.oe == (OPEN_DRAIN ? ~q.wdo_n : 1'b1))
        else $error("pin enable wrong for variant");

    pulse_seen_c: cover property ($fell(q.wdo_n));
    kick_run_c:   cover property (q.st == pswt_pkg::ST_RUN && kick_edge);
    off_seen_c:   cover property (q.st == pswt_pkg::ST_PULSE ##1 off);

endmodule // pswt_top

`default_nettype wire

//--- core/pswt_cfg.svh
// Timing and code constants for the pin select watchdog.
// Assumes a 100 MHz core clock; all long times are counted in 1 ms ticks.
`ifndef PSWT_CFG_SVH
`define PSWT_CFG_SVH

// Core clock period and time base tick length
`define PSWT_CLK_NS        10
`define PSWT_TICK_NS       1000000

// Nominal terminal counts in ms, one per select code except the off code 011 (inside min..max)
`define PSWT_T000_MS       18'h00002
`define PSWT_T001_MS       18'h00014
`define PSWT_T010_MS       18'h0003c
`define PSWT_T100_MS       18'h000c8
`define PSWT_T101_MS       18'h007d0
`define PSWT_T110_MS       18'h04e20
`define PSWT_T111_MS       18'h1d4c0

// Select code that switches supervision off
`define PSWT_SEL_OFF       3'h3

// Output pulse widths in ms for the two output variants
`define PSWT_PULSE_OD_MS   18'h00064
`define PSWT_PULSE_PP_MS   18'h00001

`endif

//--- core/pswt_pkg.sv
// Types shared by the pin select watchdog.
// Assumes pswt_cfg.svh supplies the numeric constants.
`default_nettype none

package pswt_pkg;

    // Supervisor phases
    typedef enum logic [1:0] {
        ST_START,
        ST_RUN,
        ST_PULSE,
        ST_OFF
    } pswt_state_t;

    // Complete state of the watchdog
    typedef struct packed {
        pswt_state_t st;
        logic [16:0] div;
        logic [17:0] cnt;
        logic        kick_prev;
        logic        wdo_n;
        logic        oe;
    } pswt_reg_t;

endpackage

`default_nettype wire

//--- verif/pswt_host.sv
// Host model: toggles the kick line at a set gap while enabled.
// Assumes the bench clock; changes on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module pswt_host (
    // Clock and control
    input  wire logic       clk_in,
    input  wire logic       run_in,
    input  wire logic [7:0] gap_in,
    // Kick line
    output var  logic       kick_out
);
    logic [7:0] cnt_q = 8'h00;  // Cycles since last toggle
    logic       kick_q = 1'b0;  // Kick level held between toggles

    always @(negedge clk_in) begin
        if (!run_in) begin
            cnt_q <= 8'h00;
        end else if (cnt_q + 8'h01 >= gap_in) begin
            cnt_q <= 8'h00;
            kick_q <= ~kick_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign kick_out = kick_q;
endmodule // pswt_host
`default_nettype wire

//--- verif/tb_top.sv
// Testbench for the watchdog with a 4 cycle tick, both output variants.
// Assumes pswt_top and the host model; inputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic       mclk = 1'b0;      // Core clock
    logic       srst = 1'b1;      // Sync reset
    logic [2:0] sel = 3'h0;       // Select code
    logic       host_run = 1'b0;  // Host kicking
    logic [7:0] host_gap = 8'h05; // Kick gap
    logic       kick;             // Kick line
    logic       wdo_n;            // Watchdog pin
    logic       wdo_oe;           // Pin enable
    logic       pp_n;             // Push-pull copy, watchdog pin
    logic       pp_oe;            // Push-pull copy, pin enable
    int miscompares = 0;
    int total_checks = 0;
    int n;

    pswt_top #(.TICK_CYCLES(4), .OPEN_DRAIN(1'b1)) dut_u (
        .mclk_in(mclk), .srst_in(srst), .kick_input_in(kick),
        .period_select_bit0_in(sel[0]), .period_select_bit1_in(sel[1]),
        .period_select_bit2_in(sel[2]),
        .timeout_pulse_n_out(wdo_n), .timeout_pulse_oe_out(wdo_oe));
    // Push-pull copy on the same inputs; it differs in pulse width and in its pin enable, which stays high
    pswt_top #(.TICK_CYCLES(4), .OPEN_DRAIN(1'b0)) dut_pp_u (
        .mclk_in(mclk), .srst_in(srst), .kick_input_in(kick),
        .period_select_bit0_in(sel[0]), .period_select_bit1_in(sel[1]),
        .period_select_bit2_in(sel[2]),
        .timeout_pulse_n_out(pp_n), .timeout_pulse_oe_out(pp_oe));
    pswt_host host_u (.clk_in(mclk), .run_in(host_run),
        .gap_in(host_gap), .kick_out(kick));

    // 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    // Range compare of counted cycles
    task automatic check_range(input string what, input int lo,
                               input int hi, input int seen);
        total_checks++;
        if (seen < lo || seen > hi) begin
            miscompares++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi,
                     seen);
        end
    endtask

    // Wait for a pin level, bounded; unknown never matches
    task automatic wait_level(input logic lvl, input int lim,
                              output int cnt);
        cnt = 0;
        while (wdo_n !== lvl && cnt < lim) begin
            @(negedge mclk);
            cnt++;
        end
    endtask

    // Count cycles with the pin not high
    task automatic count_low(input int cyc, output int lows);
        lows = 0;
        repeat (cyc) begin
            @(negedge mclk);
            if (wdo_n !== 1'b1) lows++;
        end
    endtask

    // Startup delay then first timeout, code 000: 8 + 8 cycles
    task automatic test_startup();
        wait_level(1'b0, 40, n);
        check_range("first fall", 15, 19, n);
    endtask

    // Low pulse of 100 ticks with enable high throughout; the push-pull
    // copy falls at the same edge and must release after one tick
    task automatic test_pulse();
        int bad;
        int pp_w;
        int pp_bad;
        bit pp_end;
        bad = 0;
        pp_w = 0;
        pp_bad = 0;
        pp_end = 1'b0;
        n = 0;
        while (wdo_n === 1'b0 && n < 500) begin
            if (wdo_oe !== 1'b1) bad++;
            if (pp_oe !== 1'b1) pp_bad++;
            if (pp_n !== 1'b1 && !pp_end) pp_w++;
            else pp_end = 1'b1;
            @(negedge mclk);
            n++;
        end
        check_range("push-pull width", 3, 5, pp_w);
        check_range("push-pull enable", 0, 0, pp_bad);
        check_range("pulse width", 398, 402, n);
        check_range("enable while low", 0, 0, bad);
        check_range("enable after", 1, 1, int'(wdo_oe === 1'b0));
    endtask

    // Kicks every 5 cycles hold off an 8 cycle timeout
    // Host controls move by non-blocking writes so the model, which also
    // wakes on the falling edge, sees them one edge later without a race
    task automatic test_kick();
        host_run <= 1'b1;
        count_low(300, n);
        check_range("lows while kicked", 0, 0, n);
        host_run <= 1'b0;
        wait_level(1'b0, 40, n);
        check_range("fall after kicks", 1, 10, n);
        test_pulse();
    endtask

    // Code 001 gives 80 cycles: a 60 cycle gap now suffices
    task automatic test_live_select();
        sel = 3'h1;
        host_gap <= 8'h3c;
        host_run <= 1'b1;
        count_low(400, n);
        check_range("lows at code 001", 0, 0, n);
        host_run <= 1'b0;
        wait_level(1'b0, 120, n);
        check_range("fall at code 001", 20, 82, n);
        wait_level(1'b1, 500, n);
        check_range("pulse at code 001", 398, 402, n);
    endtask

    // Back to 000 right after a pulse: the count restarted at pulse end,
    // so 8 cycles later it fires; code 011 then aborts that pulse, keeps
    // the pin quiet, and leaving it replays the startup delay
    task automatic test_disable();
        sel = 3'h0;
        wait_level(1'b0, 40, n);
        check_range("fall after pulse end", 7, 9, n);
        repeat (3) @(negedge mclk);
        sel = 3'h3;
        wait_level(1'b1, 4, n);
        check_range("off ends pulse", 1, 1, n);
        count_low(1000, n);
        check_range("lows when off", 0, 0, n);
        sel = 3'h0;
        wait_level(1'b0, 40, n);
        check_range("fall after off", 15, 19, n);
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog: the run needs about 3000 cycles
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (6) @(negedge mclk);
        srst = 1'b0;
        test_startup();
        test_pulse();
        test_kick();
        test_live_select();
        test_disable();
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
